// file: verilog/axis_move_regs.vh
// Register map and constants of the axis move command unit
// Assumes inclusion by the single design file; definitions only
`ifndef AXIS_MOVE_REGS_VH
`define AXIS_MOVE_REGS_VH
`define OFF_CTRL 12'h000
`define OFF_DIST 12'h004
`define OFF_TARGET 12'h008
`define OFF_VEL 12'h00c
`define OFF_ACC 12'h010
`define OFF_DEC 12'h014
`define OFF_JERK 12'h018
`define OFF_MODE 12'h01c
`define OFF_STATUS 12'h020
`define OFF_POS 12'h024
`define OFF_FAULT 12'h028
`define CTRL_REL_BIT 0
`define CTRL_ABS_BIT 1
`define CTRL_ALARM_BIT 2
`define CTRL_OFFLINE_BIT 3
`define CTRL_ROTARY_BIT 4
`define MODE_TURN_LSB 0
`define MODE_POLICY_LSB 4
`define MODE_AXIS_LSB 8
`define TURN_RESET 3'h1
`define POLICY_RESET 3'h0
`define FAULT_ALARM 16'h0001
`define FAULT_OFFLINE 16'h0002
`define FAULT_BAD_POS 16'h0003
`define STEP_RESET 32'h0000_0001
`endif

// file: verilog/axis_move_command_unit.v
// Axis move command unit: relative and absolute moves of one axis, APB slave
// Assumes one 100 MHz pclk, asynchronous active-low presetn, APB master
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "axis_move_regs.vh"
module axis_move_command_unit #(
    parameter POS_W = 32, // Position width
    parameter [POS_W-1:0] MODULO = 32'd360000 // Rotary modulo
) (
    input wire pclk, // APB clock
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error on address above the fault register
    output reg busy_q, // Move in progress
    output reg active_q, // Axis under control
    output reg done_q, // Move completed
    output reg preempted_flag_q, // Running move was pre-empted
    output reg error_q, // Move failed
    output reg [15:0] fault_code_q, // Fault code of failure
    output reg [POS_W-1:0] cmd_pos_q // Commanded axis position
);
    localparam ST_IDLE = 2'd0;
    localparam ST_REL = 2'd1;
    localparam ST_ABS = 2'd2;

    // Sequencer state and launch-edge history
    reg [1:0] state_q; // Idle, relative or absolute move
    reg [4:0] ctrl_prev_q; // Control bits one clock ago
    // Registers written over the bus
    reg [4:0] ctrl_q; // Launch, fault and rotary bits
    reg [POS_W-1:0] dist_q; // Relative distance
    reg [POS_W-1:0] target_q; // Absolute target
    reg [POS_W-1:0] vel_q; // Step per clock
    reg [POS_W-1:0] acc_q; // Acceleration, latched only
    reg [POS_W-1:0] dec_q; // Deceleration, latched only
    reg [POS_W-1:0] jerk_q; // Jerk, latched only
    reg [15:0] mode_q; // Turn sense, policy and axis number
    // Parameters captured on the launch edge
    reg [POS_W-1:0] goal_q; // Position the move ends at
    reg [POS_W-1:0] lat_vel_q; // Captured step
    reg [POS_W-1:0] lat_acc_q; // Captured acceleration
    reg [POS_W-1:0] lat_dec_q; // Captured deceleration
    reg [POS_W-1:0] lat_jerk_q; // Captured jerk
    reg [2:0] lat_turn_q; // Captured turn sense
    reg [2:0] lat_policy_q; // Captured queueing policy
    reg [7:0] lat_axis_q; // Captured axis number
    // Move bookkeeping
    reg dir_neg_q; // Absolute move runs downward
    reg act_pend_q; // Active due next clock
    reg pre_pend_q; // Pre-empted flag due next clock
    reg early_fall_q; // Launch request fell during the move
    reg [POS_W-1:0] cmd_pos_d; // Next commanded position

    // Bus phases
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pwrite & pready;
    wire apb_rd_setup = apb_setup & ~pwrite;
    // Launch request edges
    wire rel_req = ctrl_q[`CTRL_REL_BIT];
    wire abs_req = ctrl_q[`CTRL_ABS_BIT];
    wire rel_rise = rel_req & ~ctrl_prev_q[`CTRL_REL_BIT];
    wire abs_rise = abs_req & ~ctrl_prev_q[`CTRL_ABS_BIT];
    wire rel_fall = ~rel_req & ctrl_prev_q[`CTRL_REL_BIT];
    wire abs_fall = ~abs_req & ctrl_prev_q[`CTRL_ABS_BIT];
    wire any_fall = rel_fall | abs_fall;
    wire any_req = rel_req | abs_req;
    wire launch = rel_rise | abs_rise;
    // Axis condition and move progress
    wire fault = ctrl_q[`CTRL_ALARM_BIT] | ctrl_q[`CTRL_OFFLINE_BIT];
    wire rotary = ctrl_q[`CTRL_ROTARY_BIT];
    wire moving = (state_q == ST_REL) || (state_q == ST_ABS);
    wire [POS_W-1:0] step = lat_vel_q;
    wire at_goal = (cmd_pos_q == goal_q);

    // Remaining distance, magnitude, toward goal
    function [POS_W-1:0] gap;
        input [POS_W-1:0] a;
        input [POS_W-1:0] b;
        begin
            gap = ($signed(a) > $signed(b)) ? a - b : b - a;
        end
    endfunction

    // Turn-sense field of the mode word
    function [2:0] turn_field;
        input [15:0] mode;
        begin
            turn_field = mode[`MODE_TURN_LSB +: 3];
        end
    endfunction

    // Rotary step downward, wrapping from below zero to the top of the circle
    function [POS_W-1:0] wrap_dn;
        input [POS_W-1:0] pos;
        input [POS_W-1:0] stp;
        begin
            if (pos < stp)
                wrap_dn = pos + MODULO - stp;
            else
                wrap_dn = pos - stp;
        end
    endfunction

    // Rotary step upward; the step must stay below the modulo or the wrap misses
    function [POS_W-1:0] wrap_up;
        input [POS_W-1:0] pos;
        input [POS_W-1:0] stp;
        begin
            if (pos + stp >= MODULO)
                wrap_up = pos + stp - MODULO;
            else
                wrap_up = pos + stp;
        end
    endfunction

    // Fault code of a refused launch; alarm outranks offline
    function [15:0] fault_of;
        input [4:0] ctrl;
        begin
            if (ctrl[`CTRL_ALARM_BIT])
                fault_of = `FAULT_ALARM;
            else
                fault_of = `FAULT_OFFLINE;
        end
    endfunction

    // Ready one cycle after setup; offsets above the fault register answered with an error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & (paddr > `OFF_FAULT);
        end
    end

    // APB slave: zero-wait writes, registered reads
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 5'h00;
            dist_q <= {POS_W{1'b0}};
            target_q <= {POS_W{1'b0}};
            vel_q <= `STEP_RESET;
            acc_q <= {POS_W{1'b0}};
            dec_q <= {POS_W{1'b0}};
            jerk_q <= {POS_W{1'b0}};
            mode_q <= {13'h0000, `TURN_RESET};
            prdata <= 32'h0000_0000;
        end else begin
            if (apb_wr) begin
                case (paddr)
                    `OFF_CTRL: ctrl_q <= pwdata[4:0];
                    `OFF_DIST: dist_q <= pwdata;
                    `OFF_TARGET: target_q <= pwdata;
                    `OFF_VEL: vel_q <= pwdata;
                    `OFF_ACC: acc_q <= pwdata;
                    `OFF_DEC: dec_q <= pwdata;
                    `OFF_JERK: jerk_q <= pwdata;
                    `OFF_MODE: mode_q <= pwdata[15:0];
                    default: ;
                endcase
            end
            if (apb_rd_setup) begin
                case (paddr)
                    `OFF_CTRL: prdata <= {27'h0, ctrl_q};
                    `OFF_DIST: prdata <= dist_q;
                    `OFF_TARGET: prdata <= target_q;
                    `OFF_VEL: prdata <= vel_q;
                    `OFF_ACC: prdata <= acc_q;
                    `OFF_DEC: prdata <= dec_q;
                    `OFF_JERK: prdata <= jerk_q;
                    `OFF_MODE: prdata <= {16'h0000, mode_q};
                    `OFF_STATUS: prdata <= {27'h0, error_q, preempted_flag_q,
                        done_q, active_q, busy_q};
                    `OFF_POS: prdata <= cmd_pos_q;
                    `OFF_FAULT: prdata <= {16'h0000, fault_code_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Move sequencer and flag logic
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            ctrl_prev_q <= 5'h00;
            goal_q <= {POS_W{1'b0}};
            lat_vel_q <= `STEP_RESET;
            lat_acc_q <= {POS_W{1'b0}};
            lat_dec_q <= {POS_W{1'b0}};
            lat_jerk_q <= {POS_W{1'b0}};
            lat_turn_q <= `TURN_RESET;
            lat_policy_q <= `POLICY_RESET;
            lat_axis_q <= 8'h00;
            dir_neg_q <= 1'b0;
            act_pend_q <= 1'b0;
            pre_pend_q <= 1'b0;
            early_fall_q <= 1'b0;
            busy_q <= 1'b0;
            active_q <= 1'b0;
            done_q <= 1'b0;
            preempted_flag_q <= 1'b0;
            error_q <= 1'b0;
            fault_code_q <= 16'h0000;
        end else begin
            ctrl_prev_q <= ctrl_q;
            // Flags clear when the launch request falls while no move runs
            if (any_fall && !moving) begin
                done_q <= 1'b0;
                error_q <= 1'b0;
                preempted_flag_q <= 1'b0;
            end
            if (any_fall && moving)
                early_fall_q <= 1'b1;
            // Done after early release stands one period only
            if (done_q && early_fall_q) begin
                done_q <= 1'b0;
                early_fall_q <= 1'b0;
            end
            // Active follows busy by one period
            if (act_pend_q) begin
                active_q <= 1'b1;
                act_pend_q <= 1'b0;
            end
            // Earlier move reported pre-empted one period after relaunch
            if (pre_pend_q) begin
                preempted_flag_q <= 1'b1;
                pre_pend_q <= 1'b0;
            end
            if ((rel_rise || abs_rise) && fault) begin
                error_q <= 1'b1;
                fault_code_q <= fault_of(ctrl_q);
                busy_q <= 1'b0;
                active_q <= 1'b0;
                act_pend_q <= 1'b0;
                state_q <= ST_IDLE;
            end else if (abs_rise && rotary && target_q >= MODULO) begin
                error_q <= 1'b1;
                fault_code_q <= `FAULT_BAD_POS; // Target outside the circle
                busy_q <= 1'b0;
                active_q <= 1'b0;
                act_pend_q <= 1'b0;
                state_q <= ST_IDLE;
            end else if (rel_rise || abs_rise) begin
                // Launch edge: sample parameters once
                lat_vel_q <= vel_q;
                lat_acc_q <= acc_q;
                lat_dec_q <= dec_q;
                lat_jerk_q <= jerk_q;
                lat_axis_q <= mode_q[`MODE_AXIS_LSB +: 8];
                lat_policy_q <= mode_q[`MODE_POLICY_LSB +: 3];
                if (rotary && abs_rise)
                    lat_turn_q <= turn_field(mode_q);
                busy_q <= 1'b1;
                act_pend_q <= 1'b1;
                done_q <= 1'b0;
                error_q <= 1'b0;
                early_fall_q <= 1'b0;
                pre_pend_q <= moving;
                if (rel_rise) begin
                    state_q <= ST_REL;
                    // Pending remaining distance kept when pre-empting a relative move
                    goal_q <= (state_q == ST_REL ? goal_q : cmd_pos_q)
                        + dist_q;
                end else begin
                    state_q <= ST_ABS;
                    goal_q <= target_q;
                end
                if (rel_rise)
                    dir_neg_q <= dist_q[POS_W-1];
                else if (rotary && turn_field(mode_q) == 3'h3)
                    dir_neg_q <= 1'b1;
                else if (rotary && turn_field(mode_q) == 3'h1)
                    dir_neg_q <= 1'b0;
                else
                    dir_neg_q <= $signed(target_q) < $signed(cmd_pos_q);
            end else if (moving) begin
                // Completion once the position has reached the goal
                if (at_goal) begin
                    done_q <= 1'b1;
                    busy_q <= 1'b0;
                    active_q <= 1'b0;
                    act_pend_q <= 1'b0;
                    state_q <= ST_IDLE;
                    if (!any_req)
                        early_fall_q <= 1'b1;
                end
            end
        end
    end

    // Next commanded position: one captured step per clock toward the goal
    always @* begin
        cmd_pos_d = cmd_pos_q;
        if (moving && !launch && !at_goal) begin
            if (gap(cmd_pos_q, goal_q) <= step) begin
                cmd_pos_d = goal_q; // Last short step lands on the goal
            end else if (rotary && state_q == ST_ABS) begin
                // Rotary absolute move runs the chosen way round the circle
                if (dir_neg_q)
                    cmd_pos_d = wrap_dn(cmd_pos_q, step);
                else
                    cmd_pos_d = wrap_up(cmd_pos_q, step);
            end else if ($signed(goal_q) < $signed(cmd_pos_q)) begin
                cmd_pos_d = cmd_pos_q - step;
            end else begin
                cmd_pos_d = cmd_pos_q + step;
            end
        end
    end

    // Commanded position register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_pos_q <= {POS_W{1'b0}};
        end else begin
            cmd_pos_q <= cmd_pos_d;
        end
    end
endmodule // axis_move_command_unit

// file: verification/axis_move_properties.sv
// Port-level checker of the axis move command unit
// Assumes a bind to the unit, seeing only its ports
`timescale 1ns/1ns
module axis_move_properties #(parameter POS_W = 32) (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire psel, // Bus select
    input wire penable, // Bus enable
    input wire pwrite, // Bus direction
    input wire [11:0] paddr, // Bus address
    input wire [31:0] pwdata, // Bus write data
    input wire [31:0] prdata, // Bus read data
    input wire pready, // Bus ready
    input wire pslverr, // Bus error
    input wire busy_q, // Move in progress
    input wire active_q, // Axis under control
    input wire done_q, // Move completed
    input wire preempted_flag_q, // Move pre-empted
    input wire error_q, // Move failed
    input wire [15:0] fault_code_q, // Fault code
    input wire [POS_W-1:0] cmd_pos_q // Commanded position
);
    reg launch_q;
    wire acc = psel && penable && pready;
    // Launch bits as last written by software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            launch_q <= 1'b0;
        else if (acc && pwrite && paddr == 12'h000)
            launch_q <= |pwdata[1:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answer, then flag timing against launch and completion
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_unmapped_refused: assert property (acc && paddr > 12'h028 |-> pslverr && (pwrite || !prdata))
        else $error("unmapped access not refused");
    a_active_after_busy: assert property (
        $rose(busy_q) && !active_q |=> active_q || error_q) else $error("active late");
    a_done_ends_busy: assert property ($rose(done_q) |-> !busy_q && !active_q)
        else $error("done with busy or active high");
    a_done_one_period: assert property (
        done_q && !launch_q && !$past(launch_q) |=> !done_q) else $error("done held");
    a_flags_clear_low: assert property (
        (error_q || preempted_flag_q) && !launch_q && !$past(launch_q) |=> !error_q
        && !preempted_flag_q) else $error("flag held after release");
    a_error_ends_busy: assert property (
        $rose(error_q) |-> !busy_q && !active_q && fault_code_q != 16'h0)
        else $error("error without fault or with busy");
    a_idle_holds_pos: assert property (!busy_q && !active_q |=> $stable(cmd_pos_q))
        else $error("position moved while idle");
    // Main scenarios
    c_done: cover property ($rose(done_q));
    c_error: cover property ($rose(error_q));
    c_preempt: cover property ($rose(preempted_flag_q));
endmodule // axis_move_properties

// file: verification/servo_axis_model.sv
// Servo axis that follows the commanded position
// Assumes the command settles between clock edges
`timescale 1ns/1ns
module servo_axis_model #(parameter POS_W = 32) (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire [POS_W-1:0] cmd_pos_q, // Commanded position
    output reg [POS_W-1:0] axis_pos_q // Actual axis position
);
    // Axis reaches each commanded point one period late
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            axis_pos_q <= {POS_W{1'b0}};
        else
            axis_pos_q <= cmd_pos_q;
    end
endmodule // servo_axis_model

// file: verification/axis_move_command_unit_tb.sv
// Self-checking bench of the axis move command unit over the register bus
// Assumes the unit, its checker and the servo model compile first
`timescale 1ns/1ns
module axis_move_command_unit_tb;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, d, base;
    wire [31:0] prdata, cmd_pos_q, axis_pos_q;
    wire pready, pslverr, busy_q, active_q, done_q, preempted_flag_q, error_q;
    wire [15:0] fault_code_q;
    reg [32:0] expq[$];
    reg seen_pre = 1'b0;
    integer miscompares = 0, n_checks = 0, seed = 32'h0f73, i, k;
    always #5 pclk = ~pclk;
    axis_move_command_unit #(.MODULO(32'd1000)) axis_move_command_unit_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .busy_q(busy_q), .active_q(active_q), .done_q(done_q), .error_q(error_q),
        .preempted_flag_q(preempted_flag_q), .fault_code_q(fault_code_q), .cmd_pos_q(cmd_pos_q));
    servo_axis_model servo_axis_model_inst (
        .pclk(pclk), .presetn(presetn), .cmd_pos_q(cmd_pos_q), .axis_pos_q(axis_pos_q));
    task check(input [127:0] what, input [32:0] seen, input [32:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d miscompares %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Bounded wait on negative edges for ready or for a finished move
    task hold(input sel);
        begin
            k = 0;
            while ((sel ? (done_q | error_q) : pready) !== 1'b1 && k < 500) begin
                @(negedge pclk);
                k = k + 1;
            end
            if (k == 500) begin
                miscompares = miscompares + 1;
                summarize;
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] dat);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= dat;
            @(posedge pclk);
            penable <= 1'b1;
            hold(1'b0);
            @(posedge pclk);
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input [11:0] a, input [31:0] dat);
        apb(1'b1, a, dat);
    endtask
    task rd(input [11:0] a, input [32:0] e);
        begin
            repeat (2) @(posedge pclk);
            expq.push_back(e);
            apb(1'b0, a, 32'h0);
        end
    endtask
    // Read answers meet the oldest noted expectation
    always @(posedge pclk) begin
        if (preempted_flag_q === 1'b1)
            seen_pre <= 1'b1;
        if (psel && penable && pready === 1'b1 && !pwrite)
            check("read", {pslverr, prdata}, expq.pop_front());
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h00c, 33'h1);
        rd(12'h01c, 33'h1);
        rd(12'h02c, 33'h1_0000_0000);
        // Relative move twice with random step and distance
        base = ($random(seed) & 32'h3) + 1;
        d = base * (($random(seed) & 32'hf) + 4);
        wr(12'h00c, base);
        wr(12'h004, d);
        for (i = 1; i <= 2; i = i + 1) begin
            wr(12'h000, 32'h1);
            hold(1'b1);
            rd(12'h024, {1'b0, d * i});
            rd(12'h020, 33'h4);
            wr(12'h000, 32'h0);
            rd(12'h020, 33'h0);
        end
        check("axis", {1'b0, axis_pos_q}, {1'b0, d * 2});
        // Relaunch mid-move adds distances; then an early release
        base = d * 2;
        wr(12'h00c, 32'h1);
        wr(12'h004, 32'd40);
        wr(12'h000, 32'h1);
        wr(12'h004, 32'd20);
        wr(12'h000, 32'h0);
        wr(12'h000, 32'h1);
        hold(1'b1);
        rd(12'h024, {1'b0, base + 32'd60});
        check("preempt", {32'h0, seen_pre}, 33'h1);
        wr(12'h000, 32'h0);
        wr(12'h000, 32'h1);
        wr(12'h000, 32'h0);
        hold(1'b1);
        rd(12'h020, 33'h0);
        // Policy codes 0 to 5 and turn codes 1 to 4, then an absolute move
        for (i = 0; i < 6; i = i + 1) begin
            d = {16'h0, 8'h01, 1'b0, i[2:0], 1'b0, 3'd1 + i[1:0]};
            wr(12'h01c, d);
            rd(12'h01c, {1'b0, d});
        end
        d = ($random(seed) & 32'hff) | 32'h1; // Odd, never the even start point
        wr(12'h008, d);
        wr(12'h000, 32'h2);
        hold(1'b1);
        rd(12'h024, {1'b0, d});
        wr(12'h000, 32'h0);
        // Rotary move the negative way wraps through zero to the target 990
        wr(12'h01c, 32'h0000_0103);
        wr(12'h008, 32'd990);
        wr(12'h000, 32'h12);
        hold(1'b1);
        rd(12'h024, 33'd990);
        wr(12'h000, 32'h0);
        // Alarm, offline and rotary target at the modulo all fail
        wr(12'h008, 32'd1000);
        for (i = 1; i <= 3; i = i + 1) begin
            wr(12'h000, i == 1 ? 32'h5 : i == 2 ? 32'h9 : 32'h12);
            hold(1'b1);
            rd(12'h028, {17'h0, i[15:0]});
            rd(12'h020, 33'h10);
            wr(12'h000, 32'h0);
            rd(12'h020, 33'h0);
        end
        rd(12'h024, 33'd990);
        summarize;
    end
endmodule // axis_move_command_unit_tb
bind axis_move_command_unit axis_move_properties #(.POS_W(POS_W)) axis_move_properties_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy_q(busy_q), .active_q(active_q), .done_q(done_q), .error_q(error_q),
    .preempted_flag_q(preempted_flag_q), .fault_code_q(fault_code_q), .cmd_pos_q(cmd_pos_q));
